/* File: hdl/asram_pkg.sv */
package asram_pkg;

  localparam int ASRAM_ADDR_W = 15;
  localparam int ASRAM_DATA_W = 8;
  localparam int ASRAM_CLK_MHZ = 40;
  localparam int ASRAM_PERIOD_NS = 25;

  // Fastest-grade timing figures, in nanoseconds.
  localparam int READ_CYCLE_MIN_NS = 70;
  localparam int WRITE_CYCLE_MIN_NS = 70;
  localparam int T_ACCESS_CE_NS = 70;
  localparam int T_ACCESS_OE_NS = 35;
  localparam int T_SELECT_TO_END_NS = 65;
  localparam int T_ADDR_TO_END_NS = 65;
  localparam int T_WRITE_PULSE_NS = 55;
  localparam int T_DATA_SETUP_NS = 30;
  localparam int WRITE_RECOVERY_STROBE_NS = 5;
  localparam int WRITE_RECOVERY_SELECT_NS = 15;
  localparam int DATA_HOLD_STROBE_NS = 0;
  localparam int T_FLOAT_NS = 25;

  function automatic int asram_min_cyc(input int ns);
    int c;
    c = (ns + ASRAM_PERIOD_NS - 1) / ASRAM_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WR_PULSE_CYC = asram_min_cyc(T_WRITE_PULSE_NS >
      T_SELECT_TO_END_NS ? T_WRITE_PULSE_NS : T_SELECT_TO_END_NS);
  localparam int WR_SETUP_CYC = asram_min_cyc(T_DATA_SETUP_NS);
  localparam int WR_REC_CYC = asram_min_cyc(WRITE_RECOVERY_STROBE_NS);
  localparam int RD_ACCESS_CYC = asram_min_cyc(T_ACCESS_CE_NS);
  localparam int RD_FLOAT_CYC = asram_min_cyc(T_FLOAT_NS);
  localparam int WR_CYCLE_CYC = asram_min_cyc(WRITE_CYCLE_MIN_NS);
  localparam int RD_CYCLE_CYC = asram_min_cyc(READ_CYCLE_MIN_NS);
  localparam logic [3:0] ASRAM_CNT_ZERO = 4'h0;

  typedef struct packed {
    logic                    write;
    logic [ASRAM_ADDR_W-1:0] addr;
    logic [ASRAM_DATA_W-1:0] wdata;
  } asram_req_t;

  typedef struct packed {
    logic                    select_n;
    logic                    out_en_n;
    logic                    strobe_n;
    logic [ASRAM_ADDR_W-1:0] addr;
  } asram_pins_t;

endpackage

/* File: hdl/asram_sync.sv */
`timescale 1ns/10ps
module asram_sync import asram_pkg::*; #(
  parameter int WIDTH = ASRAM_DATA_W
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // Stage one feeds stage two only; a value counts once two and three agree.
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  always_comb begin
    out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end else begin
      s1_reg  <= din;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;

endmodule

/* File: hdl/asram_host.sv */
`timescale 1ns/10ps
module asram_host import asram_pkg::*; #(
  parameter int ADDR_W = ASRAM_ADDR_W,
  parameter int DATA_W = ASRAM_DATA_W
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_rdata,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic                   mem_select_n,
  output logic                   mem_out_en_n,
  output logic                   mem_strobe_n,
  input  wire logic [DATA_W-1:0] mem_dq_i,
  output logic      [DATA_W-1:0] mem_dq_o,
  output logic                   mem_dq_oe
);

  if (ADDR_W != ASRAM_ADDR_W || DATA_W != ASRAM_DATA_W) begin
    $error("asram_host: only 15-bit address and 8-bit data are served");
  end

  //////////////////////////////////////////////////////////////////////////
  // Data pin input synchroniser.

  logic [DATA_W-1:0] dq_sync;

  asram_sync #(
    .WIDTH (DATA_W)
  ) u_dq_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (mem_dq_i),
    .dout  (dq_sync)
  );

  //////////////////////////////////////////////////////////////////////////
  // Access sequencer.

  typedef enum logic [2:0] {
    ASRAM_IDLE,
    ASRAM_WR_SETUP,
    ASRAM_WR_PULSE,
    ASRAM_WR_RECOVER,
    ASRAM_RD_ACCESS,
    ASRAM_RD_SAMPLE,
    ASRAM_RD_FLOAT
  } asram_state_t;

  // The read wait covers access time plus the three-stage input pipeline.
  localparam int RD_WAIT_CYC = RD_ACCESS_CYC + 3;
  localparam logic [3:0] CNT_WR_SETUP = 4'(WR_SETUP_CYC);
  localparam logic [3:0] CNT_WR_PULSE = 4'(WR_PULSE_CYC);
  localparam logic [3:0] CNT_WR_REC = 4'(WR_REC_CYC);
  localparam logic [3:0] CNT_RD_WAIT = 4'(RD_WAIT_CYC);
  localparam logic [3:0] CNT_RD_FLOAT = 4'(RD_FLOAT_CYC);
  localparam logic [3:0] CNT_ONE = 4'h1;

  if (RD_WAIT_CYC > 15 || WR_PULSE_CYC > 15) begin
    $error("asram_host: wait counts exceed the counter width");
  end

  asram_state_t      state_reg;
  asram_state_t      state_next;
  logic [3:0]        cnt_reg;
  logic [3:0]        cnt_next;
  asram_req_t        req_reg;
  asram_req_t        req_next;
  asram_pins_t       pins_reg;
  asram_pins_t       pins_next;
  logic [DATA_W-1:0] dq_o_reg;
  logic [DATA_W-1:0] dq_o_next;
  logic              dq_oe_reg;
  logic              dq_oe_next;
  logic              ready_reg;
  logic              ready_next;
  logic              rsp_valid_reg;
  logic              rsp_valid_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              cnt_done;

  assign cnt_done = (cnt_reg == CNT_ONE) || (cnt_reg == ASRAM_CNT_ZERO);

  always_comb begin
    state_next     = state_reg;
    cnt_next       = (cnt_reg == ASRAM_CNT_ZERO) ? cnt_reg : cnt_reg - CNT_ONE;
    req_next       = req_reg;
    pins_next      = pins_reg;
    dq_o_next      = dq_o_reg;
    dq_oe_next     = dq_oe_reg;
    ready_next     = 1'b0;
    rsp_valid_next = 1'b0;
    rdata_next     = rdata_reg;
    case (state_reg)
      ASRAM_IDLE: begin
        ready_next = 1'b1;
        if (req_valid && ready_reg) begin
          ready_next     = 1'b0;
          req_next.write = req_write;
          req_next.addr  = req_addr;
          req_next.wdata = req_wdata;
          // Address moves only while select and strobe are high.
          pins_next.addr = req_addr;
          if (req_write) begin
            // Output enable stays high so the device never drives.
            pins_next.out_en_n = 1'b1;
            // Select falls first; strobe later marks the write start.
            pins_next.select_n = 1'b0;
            dq_o_next  = req_wdata;
            dq_oe_next = 1'b1;
            cnt_next   = CNT_WR_SETUP;
            state_next = ASRAM_WR_SETUP;
          end else begin
            pins_next.strobe_n = 1'b1;
            pins_next.select_n = 1'b0;
            pins_next.out_en_n = 1'b0;
            dq_oe_next = 1'b0;
            cnt_next   = CNT_RD_WAIT;
            state_next = ASRAM_RD_ACCESS;
          end
        end
      end
      ASRAM_WR_SETUP: begin
        if (cnt_done) begin
          pins_next.strobe_n = 1'b0;
          cnt_next   = CNT_WR_PULSE;
          state_next = ASRAM_WR_PULSE;
        end
      end
      ASRAM_WR_PULSE: begin
        // Select and data stay put for the whole pulse, which meets the
        // select-to-end and data-setup minimums too.
        if (cnt_done) begin
          pins_next.strobe_n = 1'b1;
          pins_next.select_n = 1'b1;
          cnt_next   = CNT_WR_REC;
          state_next = ASRAM_WR_RECOVER;
        end
      end
      ASRAM_WR_RECOVER: begin
        // Data is released one cycle after end of write; zero hold is allowed.
        dq_oe_next = 1'b0;
        if (cnt_done) begin
          state_next = ASRAM_IDLE;
          ready_next = 1'b1;
        end
      end
      ASRAM_RD_ACCESS: begin
        if (cnt_done) begin
          state_next = ASRAM_RD_SAMPLE;
        end
      end
      ASRAM_RD_SAMPLE: begin
        rdata_next         = dq_sync;
        rsp_valid_next     = 1'b1;
        pins_next.select_n = 1'b1;
        pins_next.out_en_n = 1'b1;
        // Bus must float before the host may drive it for a write.
        cnt_next   = CNT_RD_FLOAT;
        state_next = ASRAM_RD_FLOAT;
      end
      ASRAM_RD_FLOAT: begin
        if (cnt_done) begin
          state_next = ASRAM_IDLE;
          ready_next = 1'b1;
        end
      end
      default: begin
        state_next = ASRAM_IDLE;
        pins_next  = '{select_n: 1'b1, out_en_n: 1'b1, strobe_n: 1'b1,
                       addr: '0};
        dq_oe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= ASRAM_IDLE;
      cnt_reg       <= ASRAM_CNT_ZERO;
      req_reg       <= '0;
      pins_reg      <= '{select_n: 1'b1, out_en_n: 1'b1, strobe_n: 1'b1,
                         addr: '0};
      dq_o_reg      <= '0;
      dq_oe_reg     <= 1'b0;
      ready_reg     <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rdata_reg     <= '0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      req_reg       <= req_next;
      pins_reg      <= pins_next;
      dq_o_reg      <= dq_o_next;
      dq_oe_reg     <= dq_oe_next;
      ready_reg     <= ready_next;
      rsp_valid_reg <= rsp_valid_next;
      rdata_reg     <= rdata_next;
    end
  end

  assign req_ready    = ready_reg;
  assign rsp_valid    = rsp_valid_reg;
  assign rsp_rdata    = rdata_reg;
  assign mem_addr     = pins_reg.addr;
  assign mem_select_n = pins_reg.select_n;
  assign mem_out_en_n = pins_reg.out_en_n;
  assign mem_strobe_n = pins_reg.strobe_n;
  assign mem_dq_o     = dq_o_reg;
  assign mem_dq_oe    = dq_oe_reg;

endmodule

/* File: tb/asram_props.sv */
`timescale 1ns/10ps
module asram_props import asram_pkg::*; (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [14:0] req_addr,
  input wire logic [7:0]  req_wdata,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_rdata,
  input wire logic [14:0] mem_addr,
  input wire logic        mem_select_n,
  input wire logic        mem_out_en_n,
  input wire logic        mem_strobe_n,
  input wire logic [7:0]  mem_dq_i,
  input wire logic [7:0]  mem_dq_o,
  input wire logic        mem_dq_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_strobe_needs_sel: assert property (
    !mem_strobe_n |-> !mem_select_n)
    else $error("strobe low without select");
  a_read_no_strobe: assert property (!mem_out_en_n |-> mem_strobe_n)
    else $error("strobe low during read");
  a_addr_hold_wr: assert property (
    !mem_strobe_n |-> $stable(mem_addr))
    else $error("address moved during write");
  a_write_pulse_len: assert property ($fell(mem_strobe_n) |->
    (!mem_select_n && !mem_strobe_n) [*3] ##1 (mem_strobe_n && mem_select_n))
    else $error("write pulse length wrong");
  a_data_setup: assert property (
    !mem_strobe_n |-> mem_dq_oe && $stable(mem_dq_o))
    else $error("write data not stable");
  a_no_bus_fight: assert property (mem_dq_oe |-> mem_out_en_n)
    else $error("host drives while output enabled");
  a_read_answer: assert property ($fell(mem_out_en_n) |->
    (!mem_select_n && !mem_out_en_n) [*7] ##1 (rsp_valid && mem_out_en_n))
    else $error("read timing wrong");
  a_select_recover: assert property ($rose(mem_select_n) |=>
    mem_select_n && mem_strobe_n)
    else $error("no recovery after select");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind asram_host asram_props u_props (
  .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
  .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr),
  .mem_select_n(mem_select_n), .mem_out_en_n(mem_out_en_n),
  .mem_strobe_n(mem_strobe_n), .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o),
  .mem_dq_oe(mem_dq_oe));

/* File: tb/asram_mem_model.sv */
`timescale 1ns/10ps
module asram_mem_model import asram_pkg::*; (
  input  wire logic [14:0] addr,
  input  wire logic        select_n,
  input  wire logic        out_en_n,
  input  wire logic        strobe_n,
  input  wire logic [7:0]  din,
  input  wire logic        slow,
  output logic      [7:0]  dout,
  output logic             drive
);
  logic [7:0] mem [0:32767];
  logic [7:0] held;
  logic       rd;
  logic       wr;
  initial begin
    drive = 1'b0;
    for (int i = 0; i < 32768; i++)
      mem[i] = i[7:0];
  end
  assign wr = !select_n && !strobe_n;
  assign rd = !select_n && !out_en_n && strobe_n;
  // The byte lands when the first of select or strobe rises.
  always @(negedge wr) mem[addr] = din;
  // Old data lingers briefly after the address moves.
  // Read after the delay so a byte just written is seen, not the old one.
  always @(addr or wr) begin
    #10;
    held = mem[addr];
  end
  // Prompt answers come at the earliest legal moment, slow ones at the limit.
  always @(rd) drive <= #(rd ? (slow ? T_ACCESS_CE_NS : 5) : 20) rd;
  // A released bus shows the inverse so stale data can never pass.
  assign dout = drive ? held : ~held;
endmodule

/* File: tb/async_sram_access_timing_test.sv */
`timescale 1ns/10ps
module async_sram_access_timing_test import asram_pkg::*;;
  logic        clk, rst_n, req_valid, req_write, req_ready, rsp_valid;
  logic [14:0] req_addr, mem_addr;
  logic [7:0]  req_wdata, rsp_rdata, dq_o, dev_dq, dq_bus;
  logic        sel_n, oe_n, stb_n, dq_oe, dev_drive, slow;
  int          miscompares, checks;
  logic [14:0] idle_pins;
  assign idle_pins = {10'h000, sel_n, oe_n, stb_n, dq_oe, req_ready};
  assign dq_bus = dq_oe ? dq_o : dev_dq;
  asram_host u_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .mem_addr(mem_addr), .mem_select_n(sel_n), .mem_out_en_n(oe_n),
    .mem_strobe_n(stb_n), .mem_dq_i(dq_bus), .mem_dq_o(dq_o),
    .mem_dq_oe(dq_oe));
  asram_mem_model u_mem (.addr(mem_addr), .select_n(sel_n), .out_en_n(oe_n),
    .strobe_n(stb_n), .din(dq_bus), .slow(slow), .dout(dev_dq),
    .drive(dev_drive));
  always #12.5 clk = ~clk;
  // The memory must never drive while the host does.
  always @(negedge clk)
    if (dq_oe === 1'b1)
      check("bus fight", 15'h0000, {14'h0000, dev_drive});
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [14:0] exp, got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Entered just after an edge; returns just after the edge that took it.
  task automatic send(input asram_req_t r);
    int n = 0;
    @(posedge clk);
    #2;
    req_valid = 1'b1;
    req_write = r.write;
    req_addr = r.addr;
    req_wdata = r.wdata;
    while (req_ready !== 1'b1 && n < 40) begin
      @(posedge clk);
      #2;
      n++;
    end
    check("ready", 15'h0001, {14'h0000, req_ready});
    @(posedge clk);
    #2;
    req_valid = 1'b0;
  endtask
  task automatic read_chk(input logic [14:0] a, input logic [7:0] exp);
    int n = 0;
    send('{1'b0, a, 8'h00});
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      #2;
      n++;
    end
    check("read latency", 15'h0007, n[14:0]);
    check("read data", {7'h00, exp}, {7'h00, rsp_rdata});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_corners();
    send('{1'b1, 15'h0000, 8'hA5});
    send('{1'b1, 15'h7FFF, 8'h3C});
    read_chk(15'h0000, 8'hA5);
    read_chk(15'h7FFF, 8'h3C);
    read_chk(15'h1234, 8'h34);
  endtask
  // A request offered while busy must be dropped, not stored.
  task automatic t_refused();
    send('{1'b1, 15'h0020, 8'h77});
    @(posedge clk);
    #2;
    req_valid = 1'b1;
    req_write = 1'b1;
    req_addr = 15'h0021;
    req_wdata = 8'h99;
    check("busy ready", 15'h0000, {14'h0000, req_ready});
    @(posedge clk);
    #2;
    req_valid = 1'b0;
    read_chk(15'h0020, 8'h77);
    read_chk(15'h0021, 8'h21);
  endtask
  // Reset in mid-write must end the access before the strobe ever falls.
  task automatic t_reset();
    send('{1'b1, 15'h0040, 8'h5A});
    @(posedge clk);
    #2;
    rst_n = 1'b0;
    #1;
    check("reset pins", 15'h001C, idle_pins);
    @(posedge clk);
    #2;
    rst_n = 1'b1;
    read_chk(15'h0040, 8'h40);
  endtask
  task automatic t_slow();
    slow = 1'b1;
    read_chk(15'h7FFF, 8'h3C);
    read_chk(15'h0101, 8'h01);
    slow = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 15'h0000;
    req_wdata = 8'h00;
    slow = 1'b0;
    repeat (5) @(posedge clk);
    #2;
    check("idle pins", 15'h001C, idle_pins);
    rst_n = 1'b1;
    t_corners();
    t_refused();
    t_slow();
    t_reset();
    finish_test();
  end
  initial begin
    #(4000 * ASRAM_PERIOD_NS);
    miscompares++;
    finish_test();
  end
endmodule
